//--- iar_pkg.sv
package iar_pkg;

    // Datapath widths
    localparam int IAR_XLEN = 32;
    localparam int IAR_IMM_W = 12;
    localparam int IAR_DEST_W = 5;
    localparam int IAR_ADR_W = 8;

    // Register byte offsets on the bus
    localparam logic [7:0] IAR_STATUS_OFS = 8'h00;
    localparam logic [7:0] IAR_IRQ_ENABLE_OFS = 8'h04;

    // Status register field positions
    localparam int IAR_ZERO_BIT = 0;
    localparam int IAR_WRAP_BIT = 1;
    localparam int IAR_GIE_BIT = 2;

    // Interrupt enable register field positions
    localparam int IAR_WRAP_EN_BIT = 1;

    // Reset values
    localparam logic IAR_ZERO_RST = 1'h0;
    localparam logic IAR_WRAP_RST = 1'h0;
    localparam logic IAR_GIE_RST = 1'h0;
    localparam logic IAR_WRAP_EN_RST = 1'h0;

    // Compare results
    localparam logic [31:0] IAR_CMP_EQ = 32'h00000000;
    localparam logic [31:0] IAR_CMP_GT = 32'h00000001;
    localparam logic [31:0] IAR_CMP_LT = 32'hffffffff;

    // Operation codes presented by the decoder
    typedef enum logic [4:0] {
        IAR_OP_ADD = 5'h00,
        IAR_OP_SUB = 5'h01,
        IAR_OP_ADDU = 5'h02,
        IAR_OP_SUBU = 5'h03,
        IAR_OP_NOT = 5'h04,
        IAR_OP_AND = 5'h05,
        IAR_OP_OR = 5'h06,
        IAR_OP_XOR = 5'h07,
        IAR_OP_SAL = 5'h08,
        IAR_OP_SAR = 5'h09,
        IAR_OP_SLL = 5'h0a,
        IAR_OP_SLR = 5'h0b,
        IAR_OP_CMP = 5'h0c,
        IAR_OP_ADDI = 5'h10,
        IAR_OP_SUBI = 5'h11,
        IAR_OP_ADDUI = 5'h12,
        IAR_OP_SUBUI = 5'h13,
        IAR_OP_NOTI = 5'h14,
        IAR_OP_ANDI = 5'h15,
        IAR_OP_ORI = 5'h16,
        IAR_OP_XORI = 5'h17,
        IAR_OP_SALI = 5'h18,
        IAR_OP_SARI = 5'h19,
        IAR_OP_SLLI = 5'h1a,
        IAR_OP_SLRI = 5'h1b,
        IAR_OP_CMPI = 5'h1c
    } iar_op_t;

endpackage

//--- iar_alu.sv
`timescale 1ns/100ps
// How it works
// - Register ops read A, B, write destination
// - Signed ops update zero and wrap flags
// - Add writes A plus B
// - Subtract writes A minus B
// - Unsigned add/sub same result, wrap untouched
// - Invert writes complement of A
// - AND, OR, XOR combine A with B
// - Arithmetic shifts by B, right keeps sign
// - Logical shifts by B, zero fill
// - Compare gives 0, 1 or -1
// - Wrap visible as flag, can interrupt
// - Zero flag readable, never interrupts
// - Immediate ops use A and 12-bit constant
// - Immediate add and subtract
// - Immediate invert complements the constant
// - Immediate AND, OR, XOR with constant
// - Immediate shifts by constant amount
// - Immediate compare gives 0, 1 or -1
// - Interrupt needs own enable and global enable
module iar_alu (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Operation request from decode and register file
    input wire logic opValid,
    input wire iar_pkg::iar_op_t opCode,
    input wire logic [iar_pkg::IAR_XLEN-1:0] srcA,
    input wire logic [iar_pkg::IAR_XLEN-1:0] sourceB,
    input wire logic [iar_pkg::IAR_IMM_W-1:0] immConst,
    input wire logic [iar_pkg::IAR_DEST_W-1:0] destSel,
    // Write-back to the register file
    output logic wbValid,
    output logic [iar_pkg::IAR_DEST_W-1:0] wbDest,
    output logic [iar_pkg::IAR_XLEN-1:0] wbData,
    // Condition flags and interrupt
    output logic zeroFlag,
    output logic arithWrapFlag,
    output logic arithWrapInterrupt,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [iar_pkg::IAR_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    import iar_pkg::*;

    typedef struct packed {
        logic wbValid;
        logic [IAR_DEST_W-1:0] wbDest;
        logic [IAR_XLEN-1:0] wbData;
        logic zero;
        logic wrap;
        logic gie;
        logic wrapEn;
        logic irq;
        logic ack;
        logic [31:0] rdata;
    } iar_state_t;

    iar_state_t s_q;
    iar_state_t s_d;

    // Next state: bus slave, datapath and flags in one place
    always_comb begin
        logic [IAR_XLEN-1:0] opB;
        logic [IAR_XLEN-1:0] sumV;
        logic [IAR_XLEN-1:0] diffV;
        logic [IAR_XLEN-1:0] res;
        logic isImm;
        logic signExt;
        logic known;
        logic updWrap;
        logic ovf;
        logic busReq;
        logic busWrite;
        opB = '0;
        sumV = '0;
        diffV = '0;
        res = '0;
        isImm = 1'b0;
        signExt = 1'b0;
        known = 1'b1;
        updWrap = 1'b1;
        ovf = 1'b0;
        busReq = wb_cyc_i && wb_stb_i;
        busWrite = busReq && wb_we_i && s_q.ack && wb_sel_i[0];
        s_d = s_q;

        // Second operand: register or extended immediate
        isImm = opCode[4];
        signExt = (opCode == IAR_OP_ADDI) || (opCode == IAR_OP_SUBI) ||
                  (opCode == IAR_OP_CMPI);
        if (!isImm) begin
            opB = sourceB;
        end else if (signExt) begin
            opB = {{(IAR_XLEN-IAR_IMM_W){immConst[IAR_IMM_W-1]}}, immConst};
        end else begin
            opB = {{(IAR_XLEN-IAR_IMM_W){1'b0}}, immConst};
        end
        // Two's complement sum and difference share the operand mux
        sumV = srcA + opB;
        diffV = srcA - opB;

        unique case (opCode)
            IAR_OP_ADD, IAR_OP_ADDI: begin
                res = sumV;
                ovf = (srcA[31] == opB[31]) && (sumV[31] != srcA[31]);
            end
            IAR_OP_SUB, IAR_OP_SUBI: begin
                res = diffV;
                ovf = (srcA[31] != opB[31]) && (diffV[31] != srcA[31]);
            end
            IAR_OP_ADDU, IAR_OP_ADDUI: begin
                res = sumV;
                updWrap = 1'b0;
            end
            IAR_OP_SUBU, IAR_OP_SUBUI: begin
                res = diffV;
                updWrap = 1'b0;
            end
            IAR_OP_NOT: begin
                res = ~srcA;
            end
            IAR_OP_NOTI: begin
                res = ~opB;
            end
            IAR_OP_AND, IAR_OP_ANDI: begin
                res = srcA & opB;
            end
            IAR_OP_OR, IAR_OP_ORI: begin
                res = srcA | opB;
            end
            IAR_OP_XOR, IAR_OP_XORI: begin
                res = srcA ^ opB;
            end
            IAR_OP_SAL, IAR_OP_SALI, IAR_OP_SLL, IAR_OP_SLLI: begin
                res = srcA << opB;
            end
            IAR_OP_SAR, IAR_OP_SARI: begin
                res = $unsigned($signed(srcA) >>> opB);
            end
            IAR_OP_SLR, IAR_OP_SLRI: begin
                res = srcA >> opB;
            end
            IAR_OP_CMP, IAR_OP_CMPI: begin
                // Signed compare, so a negative immediate compares as negative
                if (srcA == opB) begin
                    res = IAR_CMP_EQ;
                end else if ($signed(srcA) > $signed(opB)) begin
                    res = IAR_CMP_GT;
                end else begin
                    res = IAR_CMP_LT;
                end
            end
            default: begin
                // Undefined code: nothing written, flags left alone
                known = 1'b0;
                updWrap = 1'b0;
            end
        endcase

        // Write-back pulse, one cycle after the request
        s_d.wbValid = opValid && known;
        if (opValid && known) begin
            s_d.wbDest = destSel;
            s_d.wbData = res;
        end

        // Software writes: global enable and wrap enable, write one clears wrap
        if (busWrite && (wb_adr_i == IAR_STATUS_OFS)) begin
            s_d.gie = wb_dat_i[IAR_GIE_BIT];
            if (wb_dat_i[IAR_WRAP_BIT]) begin
                s_d.wrap = 1'b0;
            end
        end
        if (busWrite && (wb_adr_i == IAR_IRQ_ENABLE_OFS)) begin
            s_d.wrapEn = wb_dat_i[IAR_WRAP_EN_BIT];
        end

        // Hardware flag update comes last so an overflow beats a clear
        if (opValid && known) begin
            s_d.zero = (res == '0);
            if (updWrap) begin
                s_d.wrap = ovf;
            end
        end

        // Only the wrap flag feeds the interrupt; zero has no source
        s_d.irq = s_d.wrap && s_d.wrapEn && s_d.gie;

        // Bus answer one cycle after the request, dropped the cycle after
        s_d.ack = busReq && !s_q.ack;
        s_d.rdata = 32'h00000000;
        if (busReq && !s_q.ack) begin
            if (wb_adr_i == IAR_STATUS_OFS) begin
                s_d.rdata[IAR_ZERO_BIT] = s_q.zero;
                s_d.rdata[IAR_WRAP_BIT] = s_q.wrap;
                s_d.rdata[IAR_GIE_BIT] = s_q.gie;
            end else if (wb_adr_i == IAR_IRQ_ENABLE_OFS) begin
                s_d.rdata[IAR_WRAP_EN_BIT] = s_q.wrapEn;
            end
        end
    end

    // State register, synchronous reset
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            s_q.wbValid <= 1'b0;
            s_q.wbDest <= '0;
            s_q.wbData <= '0;
            s_q.zero <= IAR_ZERO_RST;
            s_q.wrap <= IAR_WRAP_RST;
            s_q.gie <= IAR_GIE_RST;
            s_q.wrapEn <= IAR_WRAP_EN_RST;
            s_q.irq <= 1'b0;
            s_q.ack <= 1'b0;
            s_q.rdata <= 32'h00000000;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state flops
    assign wbValid = s_q.wbValid;
    assign wbDest = s_q.wbDest;
    assign wbData = s_q.wbData;
    assign zeroFlag = s_q.zero;
    assign arithWrapFlag = s_q.wrap;
    assign arithWrapInterrupt = s_q.irq;
    assign wb_dat_o = s_q.rdata;
    assign wb_ack_o = s_q.ack;

    // Checks on the datapath and flags
    property p_dest;
        @(posedge core_clk) disable iff (!nrst)
        (opValid && opCode == IAR_OP_AND) |=> (wbValid && wbDest == $past(destSel));
    endproperty
    a_dest: assert property (p_dest) else $error("destination not written");

    property p_add;
        @(posedge core_clk) disable iff (!nrst)
        (opValid && opCode == IAR_OP_ADD) |=>
            (wbData == 32'($past(srcA) + $past(sourceB)));
    endproperty
    a_add: assert property (p_add) else $error("add result wrong");

    property p_sub;
        @(posedge core_clk) disable iff (!nrst)
        (opValid && opCode == IAR_OP_SUB) |=>
            (wbData == 32'($past(srcA) - $past(sourceB)));
    endproperty
    a_sub: assert property (p_sub) else $error("sub result wrong");

    property p_unsigned_hold;
        @(posedge core_clk) disable iff (!nrst)
        (opValid && (opCode == IAR_OP_ADDU || opCode == IAR_OP_SUBUI) &&
         !(wb_cyc_i && wb_stb_i && wb_we_i)) |=> (arithWrapFlag == $past(arithWrapFlag));
    endproperty
    a_unsigned_hold: assert property (p_unsigned_hold) else $error("unsigned op moved wrap");

    property p_inv;
        @(posedge core_clk) disable iff (!nrst)
        (opValid && opCode == IAR_OP_NOT) |=> (wbData == ~$past(srcA));
    endproperty
    a_inv: assert property (p_inv) else $error("invert result wrong");

    property p_xor;
        @(posedge core_clk) disable iff (!nrst)
        (opValid && opCode == IAR_OP_XOR) |=> (wbData == ($past(srcA) ^ $past(sourceB)));
    endproperty
    a_xor: assert property (p_xor) else $error("xor result wrong");

    property p_sar;
        @(posedge core_clk) disable iff (!nrst)
        (opValid && opCode == IAR_OP_SAR && srcA[31] && sourceB < 32'h00000020) |=>
            wbData[31];
    endproperty
    a_sar: assert property (p_sar) else $error("right shift lost sign");

    property p_slr;
        @(posedge core_clk) disable iff (!nrst)
        (opValid && opCode == IAR_OP_SLR && sourceB != 32'h00000000) |=> !wbData[31];
    endproperty
    a_slr: assert property (p_slr) else $error("logical shift did not zero fill");

    property p_cmp;
        @(posedge core_clk) disable iff (!nrst)
        (opValid && opCode == IAR_OP_CMP && $signed(srcA) < $signed(sourceB)) |=>
            (wbData == IAR_CMP_LT);
    endproperty
    a_cmp: assert property (p_cmp) else $error("compare less gave wrong code");

    property p_cmpi_eq;
        @(posedge core_clk) disable iff (!nrst)
        (opValid && opCode == IAR_OP_CMPI && srcA == 32'h00000000 &&
         immConst == 12'h000) |=> (wbData == IAR_CMP_EQ && zeroFlag);
    endproperty
    a_cmpi_eq: assert property (p_cmpi_eq) else $error("immediate compare equal wrong");

    property p_addi_ext;
        @(posedge core_clk) disable iff (!nrst)
        (opValid && opCode == IAR_OP_ADDI && srcA == 32'h00000000 &&
         immConst == 12'hfff) |=> (wbData == 32'hffffffff);
    endproperty
    a_addi_ext: assert property (p_addi_ext) else $error("immediate not sign extended");

    property p_noti;
        @(posedge core_clk) disable iff (!nrst)
        (opValid && opCode == IAR_OP_NOTI) |=>
            (wbData == ~{20'h00000, $past(immConst)});
    endproperty
    a_noti: assert property (p_noti) else $error("immediate invert wrong");

    property p_wrap_set;
        @(posedge core_clk) disable iff (!nrst)
        (opValid && opCode == IAR_OP_ADD && srcA == 32'h7fffffff &&
         sourceB == 32'h00000001) |=> arithWrapFlag;
    endproperty
    a_wrap_set: assert property (p_wrap_set) else $error("overflow not flagged");

    property p_irq;
        @(posedge core_clk) disable iff (!nrst)
        arithWrapInterrupt |-> (arithWrapFlag && s_q.wrapEn && s_q.gie);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt without enables");

    property p_zero_no_irq;
        @(posedge core_clk) disable iff (!nrst)
        (zeroFlag && !arithWrapFlag) |-> !arithWrapInterrupt;
    endproperty
    a_zero_no_irq: assert property (p_zero_no_irq) else $error("zero flag raised interrupt");

    property p_ack_pulse;
        @(posedge core_clk) disable iff (!nrst)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");

    // Undefined codes must neither write back nor touch the zero flag
    property p_undef_quiet;
        @(posedge core_clk) disable iff (!nrst)
        (opValid && opCode[3:0] > 4'hc) |=> (!wbValid && $stable(zeroFlag));
    endproperty
    a_undef_quiet: assert property (p_undef_quiet) else $error("undefined code wrote back");

    // Zero flag follows every defined result, logic and compare included
    property p_zero_set;
        @(posedge core_clk) disable iff (!nrst)
        (opValid && opCode[3:0] <= 4'hc) |=> (zeroFlag == (wbData == 32'h00000000));
    endproperty
    a_zero_set: assert property (p_zero_set) else $error("zero flag disagrees with result");

    // Every fresh bus request is answered at the next edge
    property p_ack_next;
        @(posedge core_clk) disable iff (!nrst)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("bus request not answered");

    // Status read shows the flags as they stood when the request was taken
    property p_status_read;
        @(posedge core_clk) disable iff (!nrst)
        (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == IAR_STATUS_OFS) |=>
            (wb_dat_o[IAR_ZERO_BIT] == $past(zeroFlag) &&
             wb_dat_o[IAR_WRAP_BIT] == $past(arithWrapFlag));
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read stale");

endmodule

//--- iar_rf_model.sv
`timescale 1ns/100ps
// Register file beside the datapath: keeps every write-back it is offered while nrst is high
module iar_rf_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Write-back from the datapath
    input wire logic wbValid,
    input wire logic [iar_pkg::IAR_DEST_W-1:0] wbDest,
    input wire logic [iar_pkg::IAR_XLEN-1:0] wbData
);
    import iar_pkg::*;
    logic [IAR_XLEN-1:0] rfMem [32];
    // Write port; not cleared by reset, so a missed write leaves an unknown behind
    always_ff @(posedge core_clk) begin
        if (nrst && wbValid) begin
            rfMem[wbDest] <= wbData;
        end
    end
endmodule

//--- test_integer_alu_reg_imm.sv
`timescale 1ns/100ps
module test_integer_alu_reg_imm;
    import iar_pkg::*;
    logic core_clk;
    logic nrst;
    logic opValid;
    iar_op_t opCode;
    logic [31:0] srcA;
    logic [31:0] sourceB;
    logic [11:0] immConst;
    logic [4:0] destSel;
    logic wbValid;
    logic [4:0] wbDest;
    logic [31:0] wbData;
    logic zeroFlag;
    logic arithWrapFlag;
    logic arithWrapInterrupt;
    logic wbCyc;
    logic wbStb;
    logic wbWe;
    logic [7:0] wbAdr;
    logic [3:0] wbSel;
    logic [31:0] wbDatI;
    logic [31:0] wbDatO;
    logic wbAck;
    logic wrapExp;
    logic [31:0] rd;
    int nErrors;
    int testsRun;

    iar_alu iar_alu_inst (.core_clk(core_clk), .nrst(nrst), .opValid(opValid),
        .opCode(opCode), .srcA(srcA), .sourceB(sourceB), .immConst(immConst),
        .destSel(destSel), .wbValid(wbValid), .wbDest(wbDest), .wbData(wbData),
        .zeroFlag(zeroFlag), .arithWrapFlag(arithWrapFlag),
        .arithWrapInterrupt(arithWrapInterrupt), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
        .wb_dat_o(wbDatO), .wb_ack_o(wbAck));
    iar_rf_model iar_rf_model_inst (.core_clk(core_clk), .nrst(nrst), .wbValid(wbValid),
        .wbDest(wbDest), .wbData(wbData));

    // 20 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        testsRun++;
        if (got !== exp) begin
            nErrors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic giveVerdict();
        $display("Counts: %0d checks, %0d mismatches", testsRun, nErrors);
        if (nErrors == 0 && testsRun > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Second operand as the decoder would widen it
    function automatic logic [31:0] opnd(iar_op_t op, logic [31:0] b, logic [11:0] imm);
        if (!op[4]) return b;
        if (op == IAR_OP_ADDI || op == IAR_OP_SUBI || op == IAR_OP_CMPI) return {{20{imm[11]}}, imm};
        return {20'h0, imm};
    endfunction

    function automatic logic [31:0] expRes(iar_op_t op, logic [31:0] a, logic [31:0] o);
        case (op[3:0])
            4'h0, 4'h2: return a + o;
            4'h1, 4'h3: return a - o;
            4'h4: return op[4] ? ~o : ~a;
            4'h5: return a & o;
            4'h6: return a | o;
            4'h7: return a ^ o;
            4'h8, 4'ha: return a << o;
            4'h9: return $signed(a) >>> o;
            4'hb: return a >> o;
            default: begin
                if (a == o) return IAR_CMP_EQ;
                return ($signed(a) > $signed(o)) ? IAR_CMP_GT : IAR_CMP_LT;
            end
        endcase
    endfunction

    function automatic logic expOvf(iar_op_t op, logic [31:0] a, logic [31:0] o, logic [31:0] r);
        if (op[3:0] == 4'h0) return (a[31] == o[31]) && (r[31] != a[31]);
        if (op[3:0] == 4'h1) return (a[31] != o[31]) && (r[31] != a[31]);
        return 1'b0;
    endfunction

    // One operation, then the write-back, flags and register file are judged
    task automatic doOp(input iar_op_t op, input logic [31:0] a, input logic [31:0] b,
            input logic [11:0] imm, input logic [4:0] d);
        logic [31:0] o;
        logic [31:0] r;
        o = opnd(op, b, imm);
        r = expRes(op, a, o);
        if (op[3:1] != 3'h1) wrapExp = expOvf(op, a, o, r);
        @(posedge core_clk);
        opValid <= 1'b1;
        opCode <= op;
        srcA <= a;
        sourceB <= b;
        immConst <= imm;
        destSel <= d;
        @(posedge core_clk);
        opValid <= 1'b0;
        @(posedge core_clk);
        chk("wbValid", 32'h1, 32'(wbValid));
        chk("wbDest", 32'(d), 32'(wbDest));
        chk("wbData", r, wbData);
        chk("zeroFlag", 32'(r == 32'h0), 32'(zeroFlag));
        chk("wrapFlag", 32'(wrapExp), 32'(arithWrapFlag));
        @(posedge core_clk);
        chk("wbValid", 32'h0, 32'(wbValid));
        chk("regFile", r, iar_rf_model_inst.rfMem[d]);
    endtask

    // Classic single Wishbone cycle; read data lands in rd
    task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge core_clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbDatI <= wd;
        do begin
            @(posedge core_clk);
            n++;
        end while (wbAck !== 1'b1);
        rd = wbDatO;
        // Ack stands at the second edge after the request rises; a hang is the watchdog's
        chk("ackDelay", 32'h2, 32'(n));
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
    endtask

    task automatic testReset();
        chk("wbValid", 32'h0, 32'(wbValid));
        chk("wrapIrq", 32'h0, 32'(arithWrapInterrupt));
        wbXfer(1'b0, IAR_STATUS_OFS, 32'h0);
        chk("status", 32'h0, rd);
        wbXfer(1'b0, IAR_IRQ_ENABLE_OFS, 32'h0);
        chk("irqEnable", 32'h0, rd);
        wbXfer(1'b1, 8'h0c, 32'hffffffff);
        wbXfer(1'b0, 8'h0c, 32'h0);
        chk("unmapped", 32'h0, rd);
        $display("Test reset done");
    endtask

    // Every register and immediate code over sign, shift and equality corners
    task automatic testAllOps();
        logic [31:0] va [5] = '{32'h7fffffff, 32'h80000000, 32'h12345678, 32'h5, 32'hfffffff0};
        logic [31:0] vb [5] = '{32'h1, 32'h1f, 32'h12345678, 32'h28, 32'h3};
        logic [11:0] vi [5] = '{12'hfff, 12'h800, 12'h7ff, 12'h005, 12'h678};
        for (int i = 0; i < 5; i++) begin
            for (int c = 0; c < 13; c++) begin
                doOp(iar_op_t'(5'(c)), va[i], vb[i], 12'h0, 5'(c + i));
                doOp(iar_op_t'(5'(c + 16)), va[i], 32'h0, vi[i], 5'(c));
            end
        end
        $display("Test all ops done");
    endtask

    // Wrap flag, its clear, and the two enables in front of the interrupt
    task automatic testWrap();
        doOp(IAR_OP_ADD, 32'h7fffffff, 32'h1, 12'h0, 5'h1);
        doOp(IAR_OP_ADDU, 32'h1, 32'h1, 12'h0, 5'h2);
        wbXfer(1'b1, IAR_IRQ_ENABLE_OFS, 32'h2);
        repeat (2) @(posedge core_clk);
        chk("wrapIrq", 32'h0, 32'(arithWrapInterrupt));
        wbXfer(1'b1, IAR_STATUS_OFS, 32'h4);
        repeat (2) @(posedge core_clk);
        chk("wrapIrq", 32'h1, 32'(arithWrapInterrupt));
        wbXfer(1'b0, IAR_STATUS_OFS, 32'h0);
        chk("status", 32'h6, rd);
        wbXfer(1'b1, IAR_STATUS_OFS, 32'h6);
        wrapExp = 1'b0;
        repeat (2) @(posedge core_clk);
        chk("wrapIrq", 32'h0, 32'(arithWrapInterrupt));
        doOp(IAR_OP_XOR, 32'h55, 32'h55, 12'h0, 5'h3);
        chk("wrapIrq", 32'h0, 32'(arithWrapInterrupt));
        wbXfer(1'b0, IAR_STATUS_OFS, 32'h0);
        chk("status", 32'h5, rd);
        doOp(IAR_OP_SUBI, 32'h80000000, 32'h0, 12'h001, 5'h4);
        chk("wrapIrq", 32'h1, 32'(arithWrapInterrupt));
        doOp(IAR_OP_OR, 32'h1, 32'h2, 12'h0, 5'h5);
        chk("wrapIrq", 32'h0, 32'(arithWrapInterrupt));
        $display("Test wrap done");
    endtask

    // Ops in consecutive cycles, the last one undefined and so ignored
    task automatic testBackToBack();
        @(posedge core_clk);
        opValid <= 1'b1;
        opCode <= IAR_OP_SUB;
        srcA <= 32'ha;
        sourceB <= 32'h3;
        destSel <= 5'h7;
        @(posedge core_clk);
        opCode <= IAR_OP_NOTI;
        immConst <= 12'h0f0;
        destSel <= 5'h8;
        @(posedge core_clk);
        opCode <= iar_op_t'(5'h0d);
        chk("wbData", 32'h7, wbData);
        @(posedge core_clk);
        opValid <= 1'b0;
        chk("wbValid", 32'h1, 32'(wbValid));
        chk("wbData", 32'hffffff0f, wbData);
        @(posedge core_clk);
        chk("wbValid", 32'h0, 32'(wbValid));
        chk("wbDest", 32'h8, 32'(wbDest));
        $display("Test back to back done");
    endtask

    // Main sequence
    initial begin
        nrst = 1'b0;
        opValid = 1'b0;
        opCode = IAR_OP_ADD;
        srcA = 32'h0;
        sourceB = 32'h0;
        immConst = 12'h0;
        destSel = 5'h0;
        wbCyc = 1'b0;
        wbStb = 1'b0;
        wbWe = 1'b0;
        wbAdr = 8'h0;
        wbSel = 4'hf;
        wbDatI = 32'h0;
        wrapExp = 1'b0;
        nErrors = 0;
        testsRun = 0;
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        testReset();
        testAllOps();
        testWrap();
        testBackToBack();
        giveVerdict();
    end

    // Watchdog, well past the roughly 600 cycles the tests need
    initial begin
        repeat (6000) @(posedge core_clk);
        nErrors++;
        giveVerdict();
    end
endmodule
